//--- verilog/pdh_regs.svh
`ifndef PDH_REGS_SVH
`define PDH_REGS_SVH

`define PDH_CLK_MHZ 125
`define PDH_TRIG_LAT_US 30
`define PDH_TRIG_LAT_CYC ((`PDH_TRIG_LAT_US * `PDH_CLK_MHZ) - 2)
`define PDH_TRIG_MIN_US 20
`define PDH_TRIG_MIN_CYC (`PDH_TRIG_MIN_US * `PDH_CLK_MHZ)
`define PDH_TICK_DIV 125

`define PDH_REG_CTRL 4'h0
`define PDH_REG_STAT 4'h1
`define PDH_REG_IRQ_STAT 4'h2
`define PDH_REG_IRQ_MASK 4'h3
`define PDH_REG_SETUP0 4'h4

`define PDH_CTRL_MODE_LSB 0
`define PDH_CTRL_RUNT_EN 2
`define PDH_CTRL_ERR_CLR 3

`define PDH_IRQ_DONE 0
`define PDH_IRQ_ERR 1
`define PDH_IRQ_RUNT 2
`define PDH_IRQ_HEAT 3

`define PDH_CTRL_RST 8'h04
`define PDH_SETUP_OPEN_RST 16'h0064
`define PDH_SETUP_CLOSE_RST 16'h0064
`define PDH_SETUP_COUNT_RST 16'h0001

`endif

//--- verilog/pdh_pkg.sv
package pdh_pkg;
	typedef enum logic [1:0] {
		PDH_MODE_SINGLE = 2'h0,
		PDH_MODE_BURST = 2'h1,
		PDH_MODE_INFINITE = 2'h3
	} pdh_mode_e;

	typedef enum logic [2:0] {
		PDH_ST_IDLE = 3'h0,
		PDH_ST_WAIT = 3'h1,
		PDH_ST_OPEN = 3'h3,
		PDH_ST_CLOSE = 3'h2
	} pdh_state_e;

	typedef struct packed {
		logic [15:0] open_time;
		logic [15:0] close_time;
		logic [15:0] pulse_count;
	} pdh_setup_s;

	typedef struct packed {
		logic heater_on;
		logic temp_reached;
		logic temp_stable;
		logic heater_fault;
	} pdh_heat_s;
endpackage : pdh_pkg

//--- verilog/pdh_sync.sv
module pdh_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Bit changes only once stages two and three agree
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					q[i] <= s3_r[i];
				end
			end
		end
	end
endmodule : pdh_sync

//--- verilog/pdh_handshake.sv
// Our own choices: the address-and-strobe port and the register offsets.
`include "pdh_regs.svh"
module pdh_handshake
	import pdh_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic trigger_in,
	input wire logic select_1,
	input wire logic select_2,
	input wire logic heater_enable,
	input wire logic reserved_in,
	input wire pdh_heat_s heat_status,
	input wire logic sys_error,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq,
	output logic burst_ready,
	output logic shot_active_n,
	output logic heater_ready,
	output logic general_error,
	output logic reserved_out,
	output logic heater_drive,
	output logic valve_open,
	output logic [1:0] setup_sel
);
	localparam logic [15:0] LAT_CYC = 16'(`PDH_TRIG_LAT_CYC);
	localparam logic [15:0] MIN_CYC = 16'(`PDH_TRIG_MIN_CYC);
	localparam logic [6:0] TICK_DIV = 7'(`PDH_TICK_DIV - 1);

	logic trig_s;
	logic sel1_s;
	logic sel2_s;
	logic heat_en_s;
	logic trig_d_r;
	logic [7:0] ctrl_r;
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	logic err_latch_r;
	pdh_setup_s setup_r [4];
	pdh_setup_s act_r;
	pdh_state_e state_r;
	logic [15:0] lat_cnt_r;
	logic [15:0] hold_cnt_r;
	logic [15:0] time_cnt_r;
	logic [15:0] shot_cnt_r;
	logic [6:0] div_r;
	logic tick;
	logic trig_rise;
	logic runt;
	logic burst_done;
	logic heat_ok;
	logic heat_ok_d_r;
	logic [3:0] irq_set;
	pdh_mode_e mode;
	logic [1:0] sel_idx;
	logic ready_nxt;
	logic [3:0] irq_clr;
	logic [3:0] irq_stat_nxt;

	// Trigger, selects and heater enable from the controller's pins pass the three-stage filtered synchronizer
	pdh_sync #(.W(4)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.d({trigger_in, select_1, select_2, heater_enable}),
		.q({trig_s, sel1_s, sel2_s, heat_en_s})
	);

	function automatic logic [1:0] setup_index(input logic s1, input logic s2);
		return {s1, s2};
	endfunction : setup_index

	function automatic logic [15:0] at_least_one(input logic [15:0] v);
		return (v == 16'h0000) ? 16'h0001 : v;
	endfunction : at_least_one

	// Three slots fill the map from offset 4 up, so setup 3 keeps its reset timing
	function automatic logic [1:0] setup_slot(input logic [3:0] a);
		return a[3:2] - 2'h1;
	endfunction : setup_slot

	assign mode = pdh_mode_e'(ctrl_r[`PDH_CTRL_MODE_LSB +: 2]);
	assign sel_idx = setup_index(sel1_s, sel2_s);
	assign setup_sel = sel_idx;
	assign trig_rise = trig_s & ~trig_d_r;
	// Microsecond enable for open/close timing
	assign tick = (div_r == TICK_DIV);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 7'h00;
		end else if (state_r == PDH_ST_IDLE || state_r == PDH_ST_WAIT || tick) begin
			div_r <= 7'h00;
		end else begin
			div_r <= div_r + 7'h01;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			trig_d_r <= 1'b0;
		end else begin
			trig_d_r <= trig_s;
		end
	end

	// Trigger high time, counted during the latency wait
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			hold_cnt_r <= 16'h0000;
		end else if (trig_rise) begin
			hold_cnt_r <= 16'h0001;
		end else if (trig_s && hold_cnt_r != 16'hFFFF) begin
			hold_cnt_r <= hold_cnt_r + 16'h0001;
		end
	end

	// A runt is decided once the wait ends; trigger must have been high long enough
	assign runt = ctrl_r[`PDH_CTRL_RUNT_EN] && (state_r == PDH_ST_WAIT) && (lat_cnt_r == 16'h0000)
		&& (hold_cnt_r < MIN_CYC) && !trig_s;

	// Last close tick of the last shot; infinite mode only ends on an error
	assign burst_done = (state_r == PDH_ST_CLOSE) && tick && (time_cnt_r == 16'h0001)
		&& (mode != PDH_MODE_INFINITE) && (shot_cnt_r == 16'h0001);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= PDH_ST_IDLE;
			lat_cnt_r <= 16'h0000;
			time_cnt_r <= 16'h0000;
			shot_cnt_r <= 16'h0000;
			act_r <= '0;
		end else begin
			case (state_r)
				PDH_ST_IDLE: begin
					if (trig_rise) begin
						state_r <= PDH_ST_WAIT;
						lat_cnt_r <= LAT_CYC;
						act_r <= setup_r[sel_idx];
					end
				end
				PDH_ST_WAIT: begin
					if (lat_cnt_r != 16'h0000) begin
						lat_cnt_r <= lat_cnt_r - 16'h0001;
					end else if (runt) begin
						state_r <= PDH_ST_IDLE;
					end else begin
						state_r <= PDH_ST_OPEN;
						time_cnt_r <= at_least_one(act_r.open_time);
						shot_cnt_r <= (mode == PDH_MODE_SINGLE) ? 16'h0001 : at_least_one(act_r.pulse_count);
					end
				end
				PDH_ST_OPEN: begin
					if (tick) begin
						if (time_cnt_r == 16'h0001) begin
							state_r <= PDH_ST_CLOSE;
							time_cnt_r <= at_least_one(act_r.close_time);
						end else begin
							time_cnt_r <= time_cnt_r - 16'h0001;
						end
					end
				end
				PDH_ST_CLOSE: begin
					if (tick) begin
						if (time_cnt_r != 16'h0001) begin
							time_cnt_r <= time_cnt_r - 16'h0001;
						end else if (burst_done || err_latch_r) begin
							state_r <= PDH_ST_IDLE;
						end else begin
							state_r <= PDH_ST_OPEN;
							time_cnt_r <= at_least_one(act_r.open_time);
							if (mode != PDH_MODE_INFINITE) begin
								shot_cnt_r <= shot_cnt_r - 16'h0001;
							end
						end
					end
				end
				default: begin
					state_r <= PDH_ST_IDLE;
				end
			endcase
		end
	end

	// Ready drops on the accepted edge itself and rises on the edge that ends the burst
	always_comb begin
		ready_nxt = 1'b0;
		case (state_r)
			PDH_ST_IDLE: begin
				ready_nxt = !trig_rise;
			end
			PDH_ST_WAIT: begin
				ready_nxt = runt;
			end
			PDH_ST_CLOSE: begin
				ready_nxt = tick && (time_cnt_r == 16'h0001) && (burst_done || err_latch_r);
			end
			default: begin
				ready_nxt = 1'b0;
			end
		endcase
	end

	// Outputs registered so the pins never glitch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			burst_ready <= 1'b1;
			shot_active_n <= 1'b1;
			valve_open <= 1'b0;
		end else begin
			burst_ready <= ready_nxt;
			shot_active_n <= !(state_r == PDH_ST_OPEN);
			valve_open <= (state_r == PDH_ST_OPEN);
		end
	end

	// Only the combined condition is shown, never which part failed
	assign heat_ok = heat_status.heater_on && heat_status.temp_reached && heat_status.temp_stable;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			heater_drive <= 1'b0;
			heater_ready <= 1'b0;
			general_error <= 1'b0;
			reserved_out <= 1'b0;
			heat_ok_d_r <= 1'b0;
		end else begin
			heater_drive <= heat_en_s;
			heater_ready <= heat_ok;
			general_error <= sys_error || heat_status.heater_fault || err_latch_r;
			reserved_out <= 1'b0;
			heat_ok_d_r <= heat_ok;
		end
	end

	// Error stays latched until software clears it
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			err_latch_r <= 1'b0;
		end else if (sys_error || heat_status.heater_fault) begin
			err_latch_r <= 1'b1;
		end else if (reg_wr && reg_addr == `PDH_REG_CTRL && reg_wdata[`PDH_CTRL_ERR_CLR]) begin
			err_latch_r <= 1'b0;
		end
	end

	assign irq_set = {heat_ok & ~heat_ok_d_r, runt, sys_error | heat_status.heater_fault, burst_done};

	// Error-clear bit is a command, so it is never stored
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `PDH_CTRL_RST;
			irq_mask_r <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == `PDH_REG_CTRL) begin
				ctrl_r <= {5'h00, reg_wdata[2:0]};
			end
			if (reg_addr == `PDH_REG_IRQ_MASK) begin
				irq_mask_r <= reg_wdata[3:0];
			end
		end
	end

	// Set beats write-one-to-clear in the same cycle
	always_comb begin
		irq_clr = 4'h0;
		if (reg_wr && reg_addr == `PDH_REG_IRQ_STAT) begin
			irq_clr = reg_wdata[3:0];
		end
		irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat_r <= 4'h0;
		end else begin
			irq_stat_r <= irq_stat_nxt;
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// Setups only writable between bursts, so a running burst keeps its timing
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				setup_r[i] <= '{`PDH_SETUP_OPEN_RST, `PDH_SETUP_CLOSE_RST, `PDH_SETUP_COUNT_RST};
			end
		end else if (reg_wr && reg_addr >= `PDH_REG_SETUP0 && state_r == PDH_ST_IDLE) begin
			case (reg_addr[1:0])
				2'h0: setup_r[setup_slot(reg_addr)].open_time <= reg_wdata;
				2'h1: setup_r[setup_slot(reg_addr)].close_time <= reg_wdata;
				2'h2: setup_r[setup_slot(reg_addr)].pulse_count <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Read data stand one cycle and fall back to zero, so no stale word lingers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr >= `PDH_REG_SETUP0) begin
				case (reg_addr[1:0])
					2'h0: reg_rdata <= setup_r[setup_slot(reg_addr)].open_time;
					2'h1: reg_rdata <= setup_r[setup_slot(reg_addr)].close_time;
					2'h2: reg_rdata <= setup_r[setup_slot(reg_addr)].pulse_count;
					default: reg_rdata <= 16'h0000;
				endcase
			end else begin
				case (reg_addr)
					`PDH_REG_CTRL: reg_rdata <= {8'h00, ctrl_r};
					`PDH_REG_STAT: reg_rdata <= {7'h00, err_latch_r, sel_idx, heater_ready, general_error,
						shot_active_n, burst_ready, 2'(state_r[1:0])};
					`PDH_REG_IRQ_STAT: reg_rdata <= {12'h000, irq_stat_r};
					`PDH_REG_IRQ_MASK: reg_rdata <= {12'h000, irq_mask_r};
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end else begin
			reg_rdata <= 16'h0000;
		end
	end
endmodule : pdh_handshake

//--- verif/pdh_handshake_monitor.sv
module pdh_handshake_monitor
	import pdh_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic select_1,
	input wire logic select_2,
	input wire logic heater_enable,
	input wire pdh_heat_s heat_status,
	input wire logic sys_error,
	input wire logic burst_ready,
	input wire logic shot_active_n,
	input wire logic heater_ready,
	input wire logic general_error,
	input wire logic reserved_out,
	input wire logic heater_drive,
	input wire logic valve_open,
	input wire logic [1:0] setup_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [12:0] lat_r;
	logic first_r;
	// Cycles since burst start, only the first shot is timed
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lat_r <= 13'h0000;
			first_r <= 1'b0;
		end else if (burst_ready) begin
			lat_r <= 13'h0000;
			first_r <= 1'b1;
		end else begin
			if (lat_r != 13'h1FFF)
				lat_r <= lat_r + 13'h0001;
			if (!shot_active_n)
				first_r <= 1'b0;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	chk_trig_latency: assert property ($fell(shot_active_n) && first_r |-> lat_r >= 13'h0E9C && lat_r <= 13'h0EB0)
		else $error("first shot latency off");
	chk_shot_in_burst: assert property (!shot_active_n |-> !burst_ready)
		else $error("shot outside burst");
	chk_ready_rise: assert property ($rose(burst_ready) |-> shot_active_n && !valve_open)
		else $error("ready rose mid shot");
	chk_valve_phase: assert property (valve_open |-> !shot_active_n)
		else $error("valve open without shot");
	chk_heat_ready: assert property (heater_ready == $past(heat_status.heater_on && heat_status.temp_reached
		&& heat_status.temp_stable))
		else $error("heater ready mismatch");
	chk_error_in: assert property (sys_error || heat_status.heater_fault |=> general_error)
		else $error("error not shown");
	chk_reserved_low: assert property (!reserved_out)
		else $error("reserved output active");
	chk_heat_follow: assert property ($rose(heater_enable) |-> ##[1:7] heater_drive)
		else $error("heater drive late");
	chk_setup_map: assert property ($stable({select_1, select_2})[*8] |-> setup_sel == {select_1, select_2})
		else $error("setup select wrong");
	cover property ($fell(burst_ready));
	cover property ($rose(heater_ready));
	cover property ($rose(general_error));
endmodule : pdh_handshake_monitor

bind pdh_handshake pdh_handshake_monitor pdh_handshake_monitor_i (.ref_clk, .rst_b, .select_1, .select_2,
	.heater_enable, .heat_status, .sys_error, .burst_ready, .shot_active_n, .heater_ready, .general_error,
	.reserved_out, .heater_drive, .valve_open, .setup_sel);

//--- verif/pdh_plc_model.sv
module pdh_plc_model #(
	parameter int SETTLE_CYC = 125
) (
	input wire logic ref_clk,
	input wire logic burst_ready,
	input wire logic fire,
	input wire logic obey_ready,
	input wire logic [15:0] hold_cyc,
	output logic trigger_in,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	initial trigger_in = 1'b0;
	initial busy = 1'b0;
	// Dropping obey_ready fires into a running burst on purpose
	always begin
		@(posedge ref_clk);
		if (fire) begin
			busy <= 1'b1;
			while (obey_ready && !burst_ready) @(posedge ref_clk);
			if (obey_ready) repeat (SETTLE_CYC) @(posedge ref_clk);
			trigger_in <= 1'b1;
			repeat (hold_cyc) @(posedge ref_clk);
			trigger_in <= 1'b0;
			busy <= 1'b0;
		end
	end
endmodule : pdh_plc_model

//--- verif/pdh_handshake_test.sv
module pdh_handshake_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, rst_b = 1'b0, trigger_in, reg_wr = 1'b0, reg_rd = 1'b0, sys_error = 1'b0, plc_busy;
	logic select_1 = 1'b0, select_2 = 1'b0, heater_enable = 1'b0, plc_fire = 1'b0, plc_obey = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, plc_hold = 16'h0000, reg_rdata;
	pdh_pkg::pdh_heat_s heat_status = 4'h0;
	logic irq, burst_ready, shot_active_n, heater_ready, general_error, reserved_out, heater_drive, valve_open;
	logic [1:0] setup_sel;
	logic san_q = 1'b1;
	int num_errors = 0, n_checks = 0, shots = 0, cyc = 0;
	pdh_handshake pdh_handshake_i (.ref_clk, .rst_b, .trigger_in, .select_1, .select_2, .heater_enable,
		.reserved_in(1'b0), .heat_status, .sys_error, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.irq, .burst_ready, .shot_active_n, .heater_ready, .general_error, .reserved_out, .heater_drive,
		.valve_open, .setup_sel);
	pdh_plc_model pdh_plc_model_i (.ref_clk, .burst_ready, .fire(plc_fire), .obey_ready(plc_obey),
		.hold_cyc(plc_hold), .trigger_in, .busy(plc_busy));
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		san_q <= shot_active_n;
		if (san_q && !shot_active_n)
			shots <= shots + 1;
		if (cyc == 60000) begin
			num_errors++;
			give_verdict();
		end
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rchk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, exp);
	endtask : rchk
	task go(input logic [15:0] h, input logic obey);
		while (plc_busy) @(posedge ref_clk);
		@(posedge ref_clk);
		plc_fire <= 1'b1;
		plc_hold <= h;
		plc_obey <= obey;
		@(posedge ref_clk);
		plc_fire <= 1'b0;
	endtask : go
	task t_regs();
		rchk(4'h4, 16'hFFFF, 16'h0064);
		rchk(4'h5, 16'hFFFF, 16'h0064);
		rchk(4'h6, 16'hFFFF, 16'h0001);
		rchk(4'h0, 16'hFFFF, 16'h0004);
		rchk(4'h7, 16'hFFFF, 16'h0000);
		// Short phases keep the run brief: 2 us open, 2 us close, 3 shots
		wr(4'h4, 16'h0002);
		wr(4'h5, 16'h0002);
		wr(4'h6, 16'h0003);
		$display("test regs done");
	endtask : t_regs
	task t_single();
		int s0;
		s0 = shots;
		wr(4'h0, 16'h0004);
		go(16'd2600, 1'b1);
		repeat (9000) @(posedge ref_clk);
		#1 chk(16'(shots - s0), 16'h0001);
		$display("test single done");
	endtask : t_single
	task t_burst();
		int s0, k, lo, hi;
		s0 = shots;
		wr(4'h0, 16'h0005);
		go(16'd2600, 1'b1);
		for (k = 0; k < 9000 && shot_active_n; k++) @(posedge ref_clk) #1;
		for (lo = 0; lo < 9000 && !shot_active_n; lo++) @(posedge ref_clk) #1;
		for (hi = 0; hi < 9000 && shot_active_n; hi++) @(posedge ref_clk) #1;
		chk(16'(lo), 16'd250);
		chk(16'(hi), 16'd250);
		go(16'd2600, 1'b0);
		repeat (6000) @(posedge ref_clk);
		#1 chk(16'(shots - s0), 16'h0003);
		chk(16'(burst_ready), 16'h0001);
		$display("test burst done");
	endtask : t_burst
	task t_runt();
		int s0;
		s0 = shots;
		wr(4'h3, 16'h0000);
		wr(4'h2, 16'h000F);
		go(16'd625, 1'b1);
		repeat (6000) @(posedge ref_clk);
		#1 chk(16'(shots - s0), 16'h0000);
		rchk(4'h2, 16'h0004, 16'h0004);
		chk(16'(irq), 16'h0000);
		wr(4'h3, 16'h0004);
		#1 chk(16'(irq), 16'h0001);
		wr(4'h2, 16'h0004);
		#1 chk(16'(irq), 16'h0000);
		$display("test runt done");
	endtask : t_runt
	task t_inf();
		int s0, k;
		s0 = shots;
		wr(4'h0, 16'h0007);
		go(16'd2600, 1'b1);
		for (k = 0; k < 9000 && shots - s0 < 3; k++) @(posedge ref_clk) #1;
		chk(16'(shots - s0 >= 3), 16'h0001);
		chk(16'(burst_ready), 16'h0000);
		@(posedge ref_clk);
		sys_error <= 1'b1;
		@(posedge ref_clk);
		sys_error <= 1'b0;
		for (k = 0; k < 2000 && !burst_ready; k++) @(posedge ref_clk) #1;
		chk(16'(burst_ready), 16'h0001);
		chk(16'(general_error), 16'h0001);
		rchk(4'h1, 16'h011F, 16'h011C);
		wr(4'h0, 16'h000C);
		repeat (3) @(posedge ref_clk);
		#1 chk(16'(general_error), 16'h0000);
		$display("test infinite done");
	endtask : t_inf
	task t_heat();
		@(posedge ref_clk);
		heater_enable <= 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 chk(16'(heater_drive), 16'h0001);
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			heat_status <= 4'(i * 2);
			repeat (3) @(posedge ref_clk);
			#1 chk(16'(heater_ready), 16'(i == 7));
		end
		@(posedge ref_clk);
		heater_enable <= 1'b0;
		heat_status <= 4'h1;
		repeat (8) @(posedge ref_clk);
		#1 chk(16'(heater_drive), 16'h0000);
		chk(16'(general_error), 16'h0001);
		@(posedge ref_clk);
		heat_status <= 4'h0;
		wr(4'h0, 16'h000C);
		$display("test heater done");
	endtask : t_heat
	task t_sel();
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			{select_1, select_2} <= 2'(i);
			repeat (8) @(posedge ref_clk);
			#1 chk(16'(setup_sel), 16'(i));
		end
		$display("test select done");
	endtask : t_sel
	task give_verdict();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (8) @(posedge ref_clk);
		t_regs();
		t_single();
		t_burst();
		t_runt();
		t_inf();
		t_heat();
		t_sel();
		give_verdict();
	end
endmodule : pdh_handshake_test
